/* File: core/smc_consts.svh */
// Purpose: named constants of the sleep mode controller
// Assumes: system clock of 25 MHz
// Notes:   definitions only
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ********************************
// Sleep control register layout
// ********************************
`define SMC_SEL_HI       3
`define SMC_SEL_LO       1
`define SMC_ALLOW_BIT    0
`define SMC_SCR_RESET    4'h0

// ********************************
// Mode codes
// ********************************
`define SMC_M_IDLE       3'h0
`define SMC_M_ADCNR      3'h1
`define SMC_M_PDOWN      3'h2
`define SMC_M_PSAVE      3'h3
`define SMC_M_RSV_A      3'h4
`define SMC_M_RSV_B      3'h5
`define SMC_M_STBY       3'h6
`define SMC_M_ESTBY      3'h7

// ********************************
// Core control register layout
// ********************************
`define SMC_BSO_BIT      6
`define SMC_BSO_EN_BIT   5
`define SMC_BSO_RESET    1'h0
`define SMC_BSO_WIN_CYC  3'h4

// ********************************
// Timing
// ********************************
`define SMC_CLK_MHZ      25
`define SMC_BOD_US       60
`define SMC_BOD_CYC      ((`SMC_BOD_US * `SMC_CLK_MHZ))
`define SMC_HALT_CYC     16'h0004
`define SMC_STBY_CYC     16'h0006
`define SMC_NOSTOP_CYC   16'h0001
`define SMC_BOD_FUSE_OFF 3'h7

`endif

/* File: core/smc_pkg.sv */
// Purpose: types of the sleep mode controller
// Assumes: nothing
// Notes:   constants live in smc_consts.svh
package smc_pkg;

	// Register write strobe with data
	typedef struct packed {
		logic       we;
		logic [7:0] data;
	} smc_wr_t;

	// Enabled interrupt requests that may wake the core
	typedef struct packed {
		logic ext_level;
		logic ext_edge;
		logic pin_toggle;
		logic twi_match;
		logic timer_irq;
		logic timer2_irq;
		logic spm_ee_ready;
		logic adc_done;
		logic wdt_irq;
		logic other_io;
	} smc_wake_t;

	// Clock domain and oscillator enables
	typedef struct packed {
		logic core_clock;
		logic program_store_clock;
		logic peripheral_clock;
		logic converter_clock;
		logic async_timer_clock;
		logic main_osc;
		logic timer_osc;
	} smc_clk_t;

	typedef enum logic [2:0] {
		SMC_RUN,
		SMC_SLEEP,
		SMC_START,
		SMC_HALT
	} smc_state_t;

endpackage

/* File: core/smc_sleep_ctrl.sv */
// Purpose: sleep entry, clock gating, wake-up and brown-out control
// Assumes: all inputs synchronous to clk; wake inputs already masked
// Notes:   clock enables feed latch-based gates downstream
`timescale 1ns/1ps
`include "smc_consts.svh"

module smc_sleep_ctrl #(
	parameter logic [15:0] TOUT_FAST_CYC = 16'h0040,
	parameter logic [15:0] TOUT_SLOW_CYC = 16'h4000
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Core side
	input  wire logic              sleep_insn,
	input  wire smc_pkg::smc_wr_t  scr_wr,
	input  wire smc_pkg::smc_wr_t  ccr_wr,
	input  wire logic              rst_event,
	// Wake sources
	input  wire smc_pkg::smc_wake_t wake_req,
	// Configuration
	input  wire logic [3:0]        clock_source_fuses,
	input  wire logic [2:0]        brownout_threshold_fuses,
	input  wire logic              adc_enabled,
	input  wire logic              timer2_enabled,
	input  wire logic              timer2_async,
	// Clock and power control
	output smc_pkg::smc_clk_t      clk_en,
	output logic                   brownout_detector_en,
	output logic                   adc_start,
	// Core sequencing
	output logic                   cpu_halt,
	output logic                   irq_accept,
	output logic                   reset_resume,
	output logic                   sleeping,
	// Register views
	output logic [3:0]             sleep_control_reg,
	output logic                   brownout_sleep_off
);
	import smc_pkg::*;

	// ********************************
	// Decode functions
	// ********************************
	function automatic smc_clk_t clk_of(input logic [2:0] m, input logic t2a);
		smc_clk_t c;
		c = '0;
		unique case (m)
			`SMC_M_IDLE: begin
				c.peripheral_clock  = 1'b1;
				c.converter_clock   = 1'b1;
				c.async_timer_clock = 1'b1;
				c.main_osc          = 1'b1;
				c.timer_osc         = t2a;
			end
			`SMC_M_ADCNR: begin
				c.converter_clock   = 1'b1;
				c.async_timer_clock = t2a;
				c.main_osc          = 1'b1;
				c.timer_osc         = t2a;
			end
			`SMC_M_PSAVE: begin
				c.async_timer_clock = 1'b1;
				c.timer_osc         = t2a;
			end
			`SMC_M_STBY: c.main_osc = 1'b1;
			`SMC_M_ESTBY: begin
				c.async_timer_clock = t2a;
				c.main_osc          = 1'b1;
				c.timer_osc         = t2a;
			end
			default: c = '0;
		endcase
		return c;
	endfunction

	// Edge requests are left out wherever the peripheral clock stops
	function automatic logic wake_of(input logic [2:0] m, input smc_wake_t w,
			input logic t2e, input logic t2a);
		logic deep;
		logic t2;
		deep = w.ext_level | w.pin_toggle | w.twi_match | w.wdt_irq;
		t2   = w.timer2_irq & t2e;
		unique case (m)
			`SMC_M_IDLE:  wake_of = |w;
			`SMC_M_ADCNR: wake_of = deep | w.adc_done | w.spm_ee_ready
				| w.timer_irq | (t2 & t2a);
			`SMC_M_PSAVE,
			`SMC_M_ESTBY: wake_of = deep | t2;
			default:      wake_of = deep;
		endcase
	endfunction

	function automatic logic is_rsv(input logic [2:0] m);
		return (m == `SMC_M_RSV_A) || (m == `SMC_M_RSV_B);
	endfunction

	// ********************************
	// State
	// ********************************
	smc_state_t  state_r, state_nxt;
	logic [2:0]  mode_r;
	logic [15:0] cnt_r, cnt_nxt;
	logic        rstw_r;
	logic [2:0]  bwin_r;
	logic        bod_off_r;

	// ********************************
	// Decode
	// ********************************
	wire logic [2:0] sel_mode   = sleep_control_reg[`SMC_SEL_HI:`SMC_SEL_LO];
	wire logic       allow      = sleep_control_reg[`SMC_ALLOW_BIT];
	wire logic       enter      = sleep_insn & allow & ~is_rsv(sel_mode);
	wire logic       deep_sel   = sel_mode[1];
	wire logic       bod_fused  = brownout_threshold_fuses != `SMC_BOD_FUSE_OFF;
	wire logic       bod_cut    = brownout_sleep_off & deep_sel & bod_fused;
	wire logic       wake_hit   = wake_of(mode_r, wake_req, timer2_enabled,
		timer2_async);
	wire smc_clk_t   sleep_clks = clk_of(sel_mode, timer2_async);
	wire logic       cnt_done   = cnt_r == 16'h0000;

	// ********************************
	// Start-up timing
	// ********************************
	// Oscillator restart time from clock source fuses
	wire logic [15:0] tout_cyc  = (clock_source_fuses[3:2] == 2'b00) ?
		TOUT_FAST_CYC : TOUT_SLOW_CYC;
	wire logic [15:0] bod_cyc   = 16'(`SMC_BOD_CYC);

	// Start-up length per mode; detector restart may dominate
	wire logic [15:0] osc_cyc   =
		(mode_r == `SMC_M_PDOWN || mode_r == `SMC_M_PSAVE) ? tout_cyc :
		(mode_r == `SMC_M_STBY || mode_r == `SMC_M_ESTBY) ? `SMC_STBY_CYC :
		`SMC_NOSTOP_CYC;
	wire logic [15:0] start_cyc = (bod_off_r && osc_cyc < bod_cyc) ?
		bod_cyc : osc_cyc;

	// ********************************
	// Brown-out sleep flag timed sequence
	// ********************************
	wire logic bso_open  = ccr_wr.we & ccr_wr.data[`SMC_BSO_EN_BIT]
		& ccr_wr.data[`SMC_BSO_BIT];
	wire logic bso_write = ccr_wr.we & ~ccr_wr.data[`SMC_BSO_EN_BIT]
		& (bwin_r != 3'h0);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (state_r != SMC_RUN && !cnt_done) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
		unique case (state_r)
			SMC_RUN: begin
				if (enter) begin
					state_nxt = SMC_SLEEP;
				end
			end
			SMC_SLEEP: begin
				if (rst_event || wake_hit) begin
					state_nxt = SMC_START;
					// Loaded one short: the cycle at zero still counts
					cnt_nxt   = start_cyc - 16'h0001;
				end
			end
			SMC_START: begin
				if (rst_event) begin
					state_nxt = SMC_RUN;
				end else if (cnt_done) begin
					if (rstw_r) begin
						state_nxt = SMC_RUN;
					end else if (wake_hit) begin
						state_nxt = SMC_HALT;
						// Core stays stopped for the halt tail
						cnt_nxt   = `SMC_HALT_CYC - 16'h0001;
					end else begin
						state_nxt = SMC_RUN;
					end
				end
			end
			SMC_HALT: begin
				if (rst_event || cnt_done) begin
					state_nxt = SMC_RUN;
				end
			end
			// Unused codes fall back to run rather than lock up
			default: begin
				state_nxt = SMC_RUN;
			end
		endcase
	end

	// ********************************
	// Sequencer registers
	// ********************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= SMC_RUN;
			cnt_r   <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Mode latched at entry so later writes cannot alter an active sleep
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r    <= `SMC_M_IDLE;
			bod_off_r <= 1'b0;
		end else if (state_r == SMC_RUN && enter) begin
			mode_r    <= sel_mode;
			bod_off_r <= bod_cut;
		end
	end

	// Reset seen during sleep, held through start-up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstw_r <= 1'b0;
		end else if (state_r == SMC_SLEEP && rst_event) begin
			rstw_r <= 1'b1;
		end else if (state_nxt == SMC_RUN) begin
			rstw_r <= 1'b0;
		end
	end

	// ********************************
	// Control registers
	// ********************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_control_reg <= `SMC_SCR_RESET;
		end else if (scr_wr.we) begin
			sleep_control_reg <= scr_wr.data[`SMC_SEL_HI:`SMC_ALLOW_BIT];
		end
	end

	// Window does not restart on a repeated open write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bwin_r             <= 3'h0;
			brownout_sleep_off <= `SMC_BSO_RESET;
		end else if (bso_write) begin
			bwin_r             <= 3'h0;
			brownout_sleep_off <= ccr_wr.data[`SMC_BSO_BIT];
		end else if (bwin_r != 3'h0) begin
			bwin_r <= bwin_r - 3'h1;
		end else if (bso_open) begin
			bwin_r <= `SMC_BSO_WIN_CYC;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Enables change only on state edges and drive latch gates,
	// so a gated domain never sees a clipped pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clk_en <= '1;
		end else if (state_nxt == SMC_SLEEP && state_r == SMC_RUN) begin
			clk_en <= sleep_clks;
		end else if (state_nxt == SMC_START) begin
			clk_en.main_osc <= 1'b1;
		end else if (state_nxt == SMC_HALT || state_nxt == SMC_RUN) begin
			clk_en <= '1;
		end
	end

	// Gating only stops clocks and never clears state contents
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpu_halt <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			cpu_halt <= state_nxt != SMC_RUN;
			sleeping <= state_nxt == SMC_SLEEP;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			brownout_detector_en <= 1'b1;
		end else begin
			brownout_detector_en <= bod_fused && !(state_nxt == SMC_SLEEP
				&& (state_r == SMC_RUN ? bod_cut : bod_off_r));
		end
	end

	// One pulse at entry; later select writes cannot retrigger it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= state_r == SMC_RUN && enter
				&& sel_mode == `SMC_M_ADCNR && adc_enabled;
		end
	end

	// Reset outranks an interrupt whose halt tail ends in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_accept   <= 1'b0;
			reset_resume <= 1'b0;
		end else begin
			irq_accept   <= state_r == SMC_HALT && cnt_done
				&& !rst_event;
			reset_resume <= state_r != SMC_RUN && state_nxt == SMC_RUN
				&& (rst_event || rstw_r);
		end
	end

endmodule

/* File: dv/smc_props.sv */
// Purpose: port checks of the sleep controller
// Assumes: one clock domain
// Notes:   bound to the top after endmodule
`timescale 1ns/1ps
module smc_props (
	input wire logic             clk,
	input wire logic             rstn,
	input wire logic             sleep_insn,
	input wire logic             adc_enabled,
	input wire smc_pkg::smc_clk_t clk_en,
	input wire logic             brownout_detector_en,
	input wire logic             adc_start,
	input wire logic             cpu_halt,
	input wire logic             irq_accept,
	input wire logic             reset_resume,
	input wire logic             sleeping,
	input wire logic [3:0]       sleep_control_reg
);
	import smc_pkg::*;
	wire [2:0] m   = sleep_control_reg[3:1];
	wire       en  = sleep_control_reg[0];
	wire       ok  = m[2:1] != 2'b10;
	wire       req = sleep_insn && !cpu_halt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_sleep_entry: assert property (
		req && en && ok |=> sleeping && cpu_halt) else $error("sleep not entered");
	a_no_allow: assert property (
		req && !en |=> !sleeping) else $error("sleep without allow");
	a_rsv_nop: assert property (
		req && !ok |=> !sleeping) else $error("reserved mode slept");
	a_idle_clk: assert property (
		sleeping && m == 3'h0 |-> !clk_en.core_clock && !clk_en.program_store_clock
		&& clk_en.peripheral_clock && clk_en.converter_clock) else $error("idle gating");
	a_adcnr_clk: assert property (
		sleeping && m == 3'h1 |-> !clk_en.core_clock && !clk_en.peripheral_clock
		&& clk_en.converter_clock) else $error("noise reduction gating");
	a_pdown_clk: assert property (
		sleeping && m == 3'h2 |-> clk_en == 7'h00) else $error("power-down gating");
	a_stby_osc: assert property (
		sleeping && m[2:1] == 2'b11 |-> clk_en.main_osc) else $error("standby osc off");
	a_adc_kick: assert property (
		$rose(sleeping) && m == 3'h1 && adc_enabled |-> adc_start) else $error("no adc start");
	a_bod_back: assert property (
		$fell(sleeping) |-> brownout_detector_en) else $error("detector still off");
	a_halt_four: assert property (
		irq_accept |-> !cpu_halt && $past(cpu_halt) && $past(cpu_halt, 4)
		&& $past(clk_en.core_clock, 4)) else $error("halt tail wrong");
	c_irq: cover property (irq_accept);
	c_rst: cover property (reset_resume);
	c_adc: cover property (adc_start);
endmodule

bind smc_sleep_ctrl smc_props smc_props_i (.clk(clk), .rstn(rstn), .sleep_insn(sleep_insn),
	.adc_enabled(adc_enabled), .clk_en(clk_en), .brownout_detector_en(brownout_detector_en),
	.adc_start(adc_start), .cpu_halt(cpu_halt), .irq_accept(irq_accept),
	.reset_resume(reset_resume), .sleeping(sleeping), .sleep_control_reg(sleep_control_reg));

/* File: dv/smc_sleep_ctrl_tb_top.sv */
// Purpose: scenario bench of the sleep controller
// Assumes: short time-outs 8 and 16
// Notes:   fuses and timer 2 enable held static
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_sleep_ctrl_tb_top;
	import smc_pkg::*;
	logic clk, rstn, sleep_insn, rst_event, go, brief, bod_en, adc_start;
	logic cpu_halt, irq_accept, reset_resume, sleeping, bso, adc_en, t2_async;
	logic [3:0] src, scr;
	smc_wr_t scr_wr, ccr_wr;
	smc_wake_t wake_req;
	smc_clk_t clk_en;
	int n_errors = 0, n_compared = 0, cyc = 0;
	smc_sleep_ctrl #(.TOUT_FAST_CYC(16'h0008), .TOUT_SLOW_CYC(16'h0010)) smc_sleep_ctrl_i (
		.clk(clk), .rstn(rstn), .sleep_insn(sleep_insn), .scr_wr(scr_wr), .ccr_wr(ccr_wr),
		.rst_event(rst_event), .wake_req(wake_req), .clock_source_fuses(4'h0),
		.brownout_threshold_fuses(3'h0), .adc_enabled(adc_en), .timer2_enabled(1'b1),
		.timer2_async(t2_async), .clk_en(clk_en), .brownout_detector_en(bod_en),
		.adc_start(adc_start), .cpu_halt(cpu_halt), .irq_accept(irq_accept),
		.reset_resume(reset_resume), .sleeping(sleeping), .sleep_control_reg(scr),
		.brownout_sleep_off(bso));
	smc_wake_model smc_wake_model_i (.clk(clk), .rstn(rstn), .sleeping(sleeping),
		.irq_accept(irq_accept), .go(go), .brief(brief), .src(src), .wake_req(wake_req));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic s, input logic [7:0] d);
		if (s) scr_wr <= '{1'b1, d};
		else ccr_wr <= '{1'b1, d};
		@(posedge clk);
		scr_wr.we <= 1'b0;
		ccr_wr.we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic nap(input logic [3:0] s);
		src <= s;
		sleep_insn <= 1'b1;
		@(posedge clk);
		sleep_insn <= 1'b0;
		@(negedge clk);
	endtask
	// Counts cycles from wake to the core running again
	task automatic wake_len(output int n, output logic a, output logic r);
		n = 0;
		while (sleeping !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
		n = 0;
		while (cpu_halt !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
		a = irq_accept;
		r = reset_resume;
	endtask
	task automatic t_refuse;
		logic [7:0] d [3] = '{8'h02, 8'h09, 8'h0B};
		for (int i = 0; i < 3; i++) begin
			wr(1'b1, d[i]);
			nap(4'h9);
			chk(scr, d[i][3:0]);
			chk(sleeping, 1'b0);
			@(posedge clk);
		end
	endtask
	task automatic t_modes;
		logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
		logic [6:0] ce [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
		int nn [6] = '{1, 1, 8, 8, 6, 6};
		int n;
		logic a, r;
		for (int i = 0; i < 6; i++) begin
			wr(1'b1, {4'h0, md[i], 1'b1});
			nap(4'h9);
			chk(sleeping, 1'b1);
			chk(clk_en, ce[i]);
			chk(adc_start, md[i] == 3'h1);
			@(posedge clk);
			go <= 1'b1;
			wake_len(n, a, r);
			chk(n, nn[i] + 4);
			chk(a, 1'b1);
			@(posedge clk);
			go <= 1'b0;
		end
	endtask
	task automatic t_faults;
		int n;
		logic a, r;
		wr(1'b1, 8'h01);
		brief <= 1'b1;
		nap(4'h9);
		@(posedge clk);
		go <= 1'b1;
		wake_len(n, a, r);
		chk(a, 1'b0);
		@(posedge clk);
		go <= 1'b0;
		brief <= 1'b0;
		wr(1'b1, 8'h05);
		nap(4'h8);
		@(posedge clk);
		go <= 1'b1;
		repeat (12) @(negedge clk);
		chk(sleeping, 1'b1);
		@(posedge clk);
		rst_event <= 1'b1;
		@(posedge clk);
		rst_event <= 1'b0;
		wake_len(n, a, r);
		chk(r, 1'b1);
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic t_bod;
		int n;
		logic a, r;
		wr(1'b0, 8'h40);
		wr(1'b0, 8'h60);
		wr(1'b0, 8'h40);
		@(negedge clk);
		chk(bso, 1'b1);
		@(posedge clk);
		wr(1'b1, 8'h05);
		nap(4'h9);
		chk(bod_en, 1'b0);
		@(posedge clk);
		go <= 1'b1;
		wake_len(n, a, r);
		chk(n, `SMC_BOD_CYC + 4);
		chk(bod_en, 1'b1);
	endtask
	// Noise reduction with converter off and timer 2 on the system clock
	task automatic t_async;
		int n;
		logic a, r;
		adc_en <= 1'b0;
		t2_async <= 1'b0;
		wr(1'b1, 8'h03);
		nap(4'h4);
		chk(adc_start, 1'b0);
		chk(clk_en, 7'h0A);
		@(posedge clk);
		go <= 1'b1;
		repeat (12) @(negedge clk);
		chk(sleeping, 1'b1);
		@(posedge clk);
		go <= 1'b0;
		src <= 4'h9;
		@(posedge clk);
		go <= 1'b1;
		wake_len(n, a, r);
		chk(n, `SMC_NOSTOP_CYC + `SMC_HALT_CYC);
		chk(a, 1'b1);
		@(posedge clk);
		go <= 1'b0;
		adc_en <= 1'b1;
		t2_async <= 1'b1;
	endtask
	initial begin
		rstn = 1'b0;
		sleep_insn = 1'b0;
		rst_event = 1'b0;
		scr_wr = '0;
		ccr_wr = '0;
		go = 1'b0;
		brief = 1'b0;
		adc_en = 1'b1;
		t2_async = 1'b1;
		src = 4'h9;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({bso, scr}, 5'h00);
		chk({bod_en, clk_en}, 8'hFF);
		@(posedge clk);
		wr(1'b0, 8'h40);
		@(negedge clk);
		chk(bso, 1'b0);
		@(posedge clk);
		t_refuse;
		t_modes;
		t_faults;
		t_async;
		t_bod;
		print_verdict;
	end
endmodule

/* File: dv/smc_wake_model.sv */
// Purpose: wake source side of the core
// Assumes: one source raised per go command
// Notes:   brief drops the level early on purpose
`timescale 1ns/1ps
module smc_wake_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Controller view
	input wire logic        sleeping,
	input wire logic        irq_accept,
	// Bench commands
	input wire logic        go,
	input wire logic        brief,
	input wire logic [3:0]  src,
	// Requests
	output smc_pkg::smc_wake_t wake_req
);
	import smc_pkg::*;
	logic [9:0] req_r;
	logic       shot_r;
	assign wake_req = smc_wake_t'(req_r);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_r  <= 10'h000;
			shot_r <= 1'b0;
		end else if (!go) begin
			req_r  <= 10'h000;
			shot_r <= 1'b0;
		end else if (!shot_r && sleeping) begin
			req_r  <= 10'h001 << src;
			shot_r <= 1'b1;
		end else if (irq_accept || brief) begin
			req_r <= 10'h000;
		end
	end
endmodule
